// *** src/tcxo_pkg.sv ***
// constants, register map and types shared by the oscillator control files
// assumes a 100 MHz system clock that also stands in for the crystal base
package tcxo_pkg;
    localparam int         TEMP_W          = 10;
    localparam int         COMP_W          = 12;
    localparam logic [7:0] CMD_DIV_SEL     = 8'h5d;
    localparam logic [7:0] CMD_CONTROL     = 8'h60;
    localparam logic [7:0] CMD_TEMP_HI     = 8'h64;
    localparam logic [7:0] CMD_TEMP_LO     = 8'h65;
    localparam logic [7:0] CMD_TUNING      = 8'h66;
    localparam logic [7:0] DIV_SEL_RESET   = 8'h00;
    localparam logic [7:0] CONTROL_RESET   = 8'h00;
    localparam logic [7:0] TUNING_RESET    = 8'h00;
    localparam logic [7:0] CTL_WRITE_MASK  = 8'h0f;
    localparam int         CTL_DIV_OE_BIT  = 3;
    localparam int         CTL_BASE_OE_BIT = 2;
    localparam int         CTL_TEST_BIT    = 1;
    localparam int         CTL_HALVE_BIT   = 0;
    localparam logic [5:0] SLAVE_ADDR_BASE = 6'h28;
    localparam logic [5:0] TEMP_LO_ZEROS   = 6'h00;

    typedef enum logic [3:0] {
        BUS_IDLE      = 4'h0,
        BUS_ADDR      = 4'h1,
        BUS_ADDR_ACK  = 4'h2,
        BUS_CMD       = 4'h3,
        BUS_CMD_ACK   = 4'h4,
        BUS_WDATA     = 4'h5,
        BUS_WDATA_ACK = 4'h6,
        BUS_RDATA     = 4'h7,
        BUS_RDATA_ACK = 4'h8
    } bus_state_t;
endpackage

// *** src/conv_if.sv ***
// link between the register side and the temperature update sequencer
// assumes both ends sit on the same clock
`timescale 1ns/100ps
interface conv_if;
    import tcxo_pkg::*;
    logic [7:0]        tuning;
    logic [TEMP_W-1:0] temp;
    modport ctrl (output tuning, input temp);
    modport conv (input tuning, output temp);
endinterface

// *** src/temp_update.sv ***
// temperature update sequencer: keeps conversions running, stores results
// assumes the sensor and trim value are logic on the same clock
`timescale 1ns/100ps
module temp_update
    import tcxo_pkg::*;
(
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    input  wire logic [tcxo_pkg::TEMP_W-1:0] sensor_data,
    input  wire logic                        sensor_done,
    input  wire logic [tcxo_pkg::COMP_W-1:0] factory_comp,
    output logic                             conv_start,
    output logic [tcxo_pkg::COMP_W-1:0]      comp_value,
    conv_if.conv                             link
);
    import tcxo_pkg::*;

    typedef struct packed {
        logic              conv_start;
        logic              busy;
        logic [TEMP_W-1:0] temp;
        logic [COMP_W-1:0] comp;
    } upd_state_t;

    upd_state_t s_r;
    upd_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.conv_start = 1'b0;
        if (!s_r.busy) begin
            // first conversion starts right after reset without any command
            s_nxt.conv_start = 1'b1;
            s_nxt.busy       = 1'b1;
        end else if (sensor_done) begin
            s_nxt.temp       = sensor_data;
            // tuning is sampled only here, so a write waits for this update
            s_nxt.comp       = factory_comp
                + {{(COMP_W-8){link.tuning[7]}}, link.tuning};
            s_nxt.conv_start = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign conv_start = s_r.conv_start;
    assign comp_value = s_r.comp;
    assign link.temp  = s_r.temp;
endmodule

// *** src/tcxo_ctrl.sv ***
// digital control of the compensated oscillator: serial slave, registers,
// output divider and clock gating; assumes clk is the crystal base clock
`timescale 1ns/100ps
module tcxo_ctrl
    import tcxo_pkg::*;
#(
    parameter bit OE_ACTIVE_LOW = 1'b1
) (
    input  wire logic                        clk,
    input  wire logic                        rst_b,
    input  wire logic                        scl_i,
    input  wire logic                        sda_i,
    output logic                             sda_o,
    output logic                             sda_oe,
    input  wire logic                        address_select_pin,
    input  wire logic [tcxo_pkg::TEMP_W-1:0] sensor_data,
    input  wire logic                        sensor_done,
    input  wire logic [tcxo_pkg::COMP_W-1:0] factory_comp,
    output logic                             conv_start,
    output logic [tcxo_pkg::COMP_W-1:0]      comp_value,
    output logic                             base_clock_out,
    output logic                             divided_clock_out
);
    import tcxo_pkg::*;

    typedef struct packed {
        logic [2:0] scl_s;
        logic [2:0] sda_s;
        logic [1:0] a0_s;
        logic [1:0] a0_cnt;
        logic       a0;
        bus_state_t st;
        logic [3:0] bit_cnt;
        logic [7:0] shreg;
        logic       rw;
        logic [7:0] ptr;
        logic       rd_lo;
        logic [7:0] tx;
        logic [7:0] snap_lo;
        logic       sda_oe;
        logic [7:0] divider_select;
        logic [7:0] ctl;
        logic [7:0] tuning;
        logic       base_ph;
        logic [7:0] div_cnt;
        logic [7:0] act_sel;
        logic       act_halve;
        logic       div_lvl;
        logic       base_out;
        logic       div_out;
    } ctrl_state_t;

    ctrl_state_t s_r;
    ctrl_state_t s_nxt;
    conv_if      link ();

    logic [7:0] temp_hi;
    logic [7:0] temp_lo;
    logic       scl;
    logic       scl_prev;
    logic       sda;
    logic       sda_prev;
    logic       bus_start;
    logic       bus_stop;
    logic       scl_rise;
    logic       scl_fall;
    logic       base_en;
    logic       div_en;
    logic       addr_hit;

    // fraction bits sit at the top of the low byte, the rest read zero
    assign temp_hi = link.temp[TEMP_W-1:2];
    assign temp_lo = {link.temp[1:0], TEMP_LO_ZEROS};

    function automatic logic [7:0] reg_read(input logic [7:0] ptr,
                                            input logic [7:0] dsel,
                                            input logic [7:0] ctl,
                                            input logic [7:0] tun,
                                            input logic [7:0] thi,
                                            input logic [7:0] tlo);
        logic [7:0] v;
        v = 8'h00;
        case (ptr)
            CMD_DIV_SEL: v = dsel;
            CMD_CONTROL: v = ctl;
            CMD_TEMP_HI: v = thi;
            CMD_TEMP_LO: v = tlo;
            CMD_TUNING:  v = tun;
            default:     v = 8'h00;
        endcase
        return v;
    endfunction

    // the pins are sampled twice before use; bit 2 is only for edges
    assign scl       = s_r.scl_s[1];
    assign scl_prev  = s_r.scl_s[2];
    assign sda       = s_r.sda_s[1];
    assign sda_prev  = s_r.sda_s[2];
    // 100 MHz oversampling leaves wide margin at 400 kHz bus rate
    assign bus_start = scl && scl_prev && sda_prev && !sda;
    assign bus_stop  = scl && scl_prev && !sda_prev && sda;
    assign scl_rise  = scl && !scl_prev;
    assign scl_fall  = !scl && scl_prev;
    assign base_en   = (s_r.ctl[CTL_BASE_OE_BIT] != OE_ACTIVE_LOW);
    assign div_en    = (s_r.ctl[CTL_DIV_OE_BIT] != OE_ACTIVE_LOW);
    assign addr_hit  = (s_r.shreg[7:1] == {SLAVE_ADDR_BASE, s_r.a0});

    always_comb begin
        s_nxt = s_r;
        s_nxt.scl_s = {s_r.scl_s[1:0], scl_i};
        s_nxt.sda_s = {s_r.sda_s[1:0], sda_i};
        s_nxt.a0_s  = {s_r.a0_s[0], address_select_pin};

        // strap is caught once the synchroniser holds a real sample
        if (s_r.a0_cnt != 2'h3) begin
            s_nxt.a0_cnt = s_r.a0_cnt + 2'h1;
        end
        if (s_r.a0_cnt == 2'h2) begin
            s_nxt.a0 = s_r.a0_s[1];
        end

        if (bus_start) begin
            s_nxt.st      = BUS_ADDR;
            s_nxt.bit_cnt = 4'h0;
            s_nxt.sda_oe  = 1'b0;
        end else if (bus_stop) begin
            s_nxt.st     = BUS_IDLE;
            s_nxt.sda_oe = 1'b0;
        end else begin
            case (s_r.st)
                BUS_ADDR, BUS_CMD, BUS_WDATA: begin
                    if (scl_rise) begin
                        s_nxt.shreg   = {s_r.shreg[6:0], sda};
                        s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                    end else if (scl_fall && s_r.bit_cnt == 4'h8) begin
                        s_nxt.bit_cnt = 4'h0;
                        s_nxt.sda_oe  = 1'b1;
                        if (s_r.st == BUS_ADDR) begin
                            if (addr_hit) begin
                                s_nxt.rw = s_r.shreg[0];
                                s_nxt.st = BUS_ADDR_ACK;
                            end else begin
                                s_nxt.sda_oe = 1'b0;
                                s_nxt.st     = BUS_IDLE;
                            end
                        end else if (s_r.st == BUS_CMD) begin
                            s_nxt.ptr   = s_r.shreg;
                            s_nxt.rd_lo = 1'b0;
                            s_nxt.st    = BUS_CMD_ACK;
                        end else begin
                            case (s_r.ptr)
                                CMD_DIV_SEL: begin
                                    s_nxt.divider_select = s_r.shreg;
                                end
                                CMD_CONTROL: begin
                                    s_nxt.ctl = s_r.shreg & CTL_WRITE_MASK;
                                end
                                CMD_TUNING:  s_nxt.tuning = s_r.shreg;
                                default:     s_nxt.tuning = s_r.tuning;
                            endcase
                            s_nxt.st = BUS_WDATA_ACK;
                        end
                    end
                end
                BUS_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (s_r.rw) begin
                            // both temperature bytes are frozen together
                            s_nxt.tx = reg_read(s_r.ptr, s_r.divider_select,
                                                s_r.ctl, s_r.tuning,
                                                temp_hi, temp_lo);
                            s_nxt.snap_lo = temp_lo;
                            s_nxt.sda_oe  = !s_nxt.tx[7];
                            s_nxt.st      = BUS_RDATA;
                        end else begin
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st     = BUS_CMD;
                        end
                    end
                end
                BUS_CMD_ACK: begin
                    if (scl_fall) begin
                        s_nxt.sda_oe = 1'b0;
                        s_nxt.st     = BUS_WDATA;
                    end
                end
                BUS_WDATA_ACK: begin
                    // further bytes are left unacknowledged: no auto-increment
                    if (scl_fall) begin
                        s_nxt.sda_oe = 1'b0;
                        s_nxt.st     = BUS_IDLE;
                    end
                end
                BUS_RDATA: begin
                    if (scl_fall) begin
                        if (s_r.bit_cnt == 4'h7) begin
                            s_nxt.sda_oe = 1'b0;
                            s_nxt.st     = BUS_RDATA_ACK;
                        end else begin
                            s_nxt.tx      = {s_r.tx[6:0], 1'b0};
                            s_nxt.sda_oe  = !s_r.tx[6];
                            s_nxt.bit_cnt = s_r.bit_cnt + 4'h1;
                        end
                    end
                end
                BUS_RDATA_ACK: begin
                    if (scl_rise && sda) begin
                        s_nxt.st = BUS_IDLE;
                    end else if (scl_fall) begin
                        if (s_r.ptr == CMD_TEMP_HI && !s_r.rd_lo) begin
                            s_nxt.tx    = s_r.snap_lo;
                            s_nxt.rd_lo = 1'b1;
                        end else begin
                            s_nxt.tx = 8'h00;
                        end
                        s_nxt.sda_oe  = !s_nxt.tx[7];
                        s_nxt.bit_cnt = 4'h0;
                        s_nxt.st      = BUS_RDATA;
                    end
                end
                default: begin
                    s_nxt.sda_oe = 1'b0;
                end
            endcase
        end

        // base clock: one flop toggle per cycle, half the system rate
        s_nxt.base_ph = !s_r.base_ph;
        if (!s_r.base_ph) begin
            if (s_r.div_cnt == s_r.act_sel) begin
                s_nxt.div_cnt   = 8'h00;
                s_nxt.act_sel   = s_r.divider_select;
                s_nxt.act_halve = s_r.ctl[CTL_HALVE_BIT];
                s_nxt.div_lvl   = !s_r.div_lvl;
            end else begin
                s_nxt.div_cnt = s_r.div_cnt + 8'h01;
            end
        end
        s_nxt.base_out = base_en && s_nxt.base_ph;
        // non-halved mode: one base-high pulse per n+1 base periods
        s_nxt.div_out  = div_en && (s_nxt.act_halve ? s_nxt.div_lvl
            : (s_nxt.div_cnt == 8'h00 && s_nxt.base_ph));
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_r                <= '0;
            s_r.divider_select <= DIV_SEL_RESET;
            s_r.ctl            <= CONTROL_RESET;
            s_r.tuning         <= TUNING_RESET;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign link.tuning       = s_r.tuning;
    assign sda_o             = 1'b0;
    assign sda_oe            = s_r.sda_oe;
    assign base_clock_out    = s_r.base_out;
    assign divided_clock_out = s_r.div_out;

    temp_update u_temp_update (
        .clk          (clk),
        .rst_b        (rst_b),
        .sensor_data  (sensor_data),
        .sensor_done  (sensor_done),
        .factory_comp (factory_comp),
        .conv_start   (conv_start),
        .comp_value   (comp_value),
        .link         (link)
    );
endmodule

// *** sim/tcxo_ctrl_sva.sv ***
// port-level checks for the oscillator control block
// assumes a bind onto tcxo_ctrl; one clock domain, reset low
`timescale 1ns/100ps
module tcxo_ctrl_sva
    import tcxo_pkg::*;
(
    input wire logic                        clk,
    input wire logic                        rst_b,
    input wire logic                        scl_i,
    input wire logic                        sda_i,
    input wire logic                        sda_o,
    input wire logic                        sda_oe,
    input wire logic                        address_select_pin,
    input wire logic [tcxo_pkg::TEMP_W-1:0] sensor_data,
    input wire logic                        sensor_done,
    input wire logic [tcxo_pkg::COMP_W-1:0] factory_comp,
    input wire logic                        conv_start,
    input wire logic [tcxo_pkg::COMP_W-1:0] comp_value,
    input wire logic                        base_clock_out,
    input wire logic                        divided_clock_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    sda_open_a: assert property (sda_o == 1'b0)
        else $error("data pin value not low");
    first_conv_a: assert property ($rose(rst_b) |=> conv_start)
        else $error("no conversion after reset");
    done_conv_a: assert property (sensor_done |=> conv_start)
        else $error("conversion not restarted");
    conv_pulse_a: assert property (
        conv_start && !sensor_done |=> !conv_start)
        else $error("conversion start too long");
    comp_hold_a: assert property (!sensor_done |=> $stable(comp_value))
        else $error("compensation moved outside update");
    base_square_a: assert property (base_clock_out |=> !base_clock_out)
        else $error("base output not a half-rate square");
    sda_scl_low_a: assert property ($changed(sda_oe) |-> !scl_i)
        else $error("data changed while serial clock high");
    quiet_start_a: assert property (
        $rose(rst_b) |-> !sda_oe && !base_clock_out && !divided_clock_out)
        else $error("outputs active out of reset");
    // a start comes from the master; the slave stays off the line after it
    start_quiet_a: assert property (
        scl_i && $fell(sda_i) |=> !sda_oe [*8])
        else $error("data pin driven right after a start");
    cover property (sensor_done ##1 conv_start);
    cover property ($rose(sda_oe));
    cover property ($rose(divided_clock_out));
endmodule

// *** sim/tcxo_bus_master.sv ***
// two-wire bus master model; bit timing in system clocks
// assumes an external pull-up resolves the data line
`timescale 1ns/100ps
module tcxo_bus_master #(
    parameter int HALF = 10
) (
    input  wire logic clk,
    input  wire logic sda,
    output logic      scl,
    output logic      sda_pull
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic hp;
        repeat (HALF) @(posedge clk);
        #1;
    endtask
    // also serves as repeated start from a low clock
    task automatic start;
        sda_pull = 1'b0;
        hp;
        scl = 1'b1;
        hp;
        sda_pull = 1'b1;
        hp;
        scl = 1'b0;
        hp;
    endtask
    task automatic stop;
        sda_pull = 1'b1;
        hp;
        scl = 1'b1;
        hp;
        sda_pull = 1'b0;
        hp;
    endtask
    // data held two clocks past the fall so the synchroniser sees no stop
    task automatic bit_x(input logic b, output logic s);
        sda_pull = !b;
        hp;
        scl = 1'b1;
        hp;
        s = sda;
        scl = 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    // rel=1 leaves the ninth bit released: nack as reader
    task automatic bx(input logic [7:0] d, input logic rel,
                      output logic [8:0] q);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i+1]);
        end
        bit_x(rel, q[0]);
    endtask
endmodule

// *** sim/tcxo_ctrl_tb_top.sv ***
// self-checking bench: register access over the two-wire bus
// assumes the package constants and the bus master model
`timescale 1ns/100ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tcxo_ctrl_tb_top;
    import tcxo_pkg::*;
    logic              clk = 1'b0;
    logic              rst_b = 1'b0;
    logic              adr_pin = 1'b1;
    logic [TEMP_W-1:0] sdata = '0;
    logic              sdone = 1'b0;
    logic [COMP_W-1:0] fcomp = 12'h400;
    logic              sda_o, sda_oe, conv_start, base_o, div_o, scl, pull;
    logic [COMP_W-1:0] comp_value;
    wire               sda = !((sda_oe && !sda_o) || pull);
    wire  [6:0]        adr = {SLAVE_ADDR_BASE, adr_pin};
    int                bad_count = 0, cmp_count = 0, cyc = 0, per, hi;
    logic [8:0]        q;
    logic [7:0]        b1, b2;
    initial forever #5 clk = !clk;
    tcxo_ctrl i_tcxo_ctrl (.clk(clk), .rst_b(rst_b), .scl_i(scl),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe),
        .address_select_pin(adr_pin), .sensor_data(sdata),
        .sensor_done(sdone), .factory_comp(fcomp), .conv_start(conv_start),
        .comp_value(comp_value), .base_clock_out(base_o),
        .divided_clock_out(div_o));
    tcxo_bus_master i_tcxo_bus_master (.clk(clk), .sda(sda), .scl(scl),
        .sda_pull(pull));
    task automatic tally_and_finish;
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // command byte is sent afresh before every access
    task automatic wr(input logic [7:0] c, input logic [7:0] d);
        i_tcxo_bus_master.start;
        i_tcxo_bus_master.bx({adr, 1'b0}, 1'b1, q);
        `CHK(q[0], 1'b0)
        i_tcxo_bus_master.bx(c, 1'b1, q);
        i_tcxo_bus_master.bx(d, 1'b1, q);
        `CHK(q[0], 1'b0)
        i_tcxo_bus_master.stop;
    endtask
    task automatic rd(input logic [7:0] c, input int nb);
        i_tcxo_bus_master.start;
        i_tcxo_bus_master.bx({adr, 1'b0}, 1'b1, q);
        i_tcxo_bus_master.bx(c, 1'b1, q);
        i_tcxo_bus_master.start;
        i_tcxo_bus_master.bx({adr, 1'b1}, 1'b1, q);
        i_tcxo_bus_master.bx(8'hff, nb == 1, q);
        b1 = q[8:1];
        if (nb == 2) begin
            i_tcxo_bus_master.bx(8'hff, 1'b1, q);
            b2 = q[8:1];
        end
        i_tcxo_bus_master.stop;
    endtask
    task automatic base_highs(output int h);
        h = 0;
        repeat (20) begin
            @(posedge clk);
            #1;
            h += int'(base_o);
        end
    endtask
    // period between two rises of the divided output, and its high time
    task automatic meas;
        int r0, r1;
        logic p;
        r0 = -1;
        r1 = -1;
        hi = 0;
        p = div_o;
        for (int t = 0; t < 300 && r1 < 0; t++) begin
            @(posedge clk);
            #1;
            if (div_o && !p) begin
                if (r0 < 0) r0 = t;
                else r1 = t;
            end
            if (r0 >= 0 && r1 < 0 && div_o) hi++;
            p = div_o;
        end
        per = r1 - r0;
    endtask
    task automatic conv(input logic [TEMP_W-1:0] d);
        @(posedge clk);
        #1;
        sdata = d;
        sdone = 1'b1;
        @(posedge clk);
        #1;
        sdone = 1'b0;
        @(posedge clk);
        #1;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        rd(CMD_DIV_SEL, 1);
        `CHK(b1, DIV_SEL_RESET)
        rd(CMD_CONTROL, 1);
        `CHK(b1, CONTROL_RESET)
        rd(CMD_TUNING, 1);
        `CHK(b1, TUNING_RESET)
        base_highs(hi);
        `CHK(hi, 10)
        meas;
        `CHK(per, 2)
        wr(CMD_DIV_SEL, 8'h03);
        meas;
        `CHK(per, 8)
        `CHK(hi, 1)
        wr(CMD_CONTROL, 8'hf1); // factory-test bit kept 0
        rd(CMD_CONTROL, 1);
        `CHK(b1, 8'h01)
        meas;
        `CHK(per, 16)
        `CHK(hi, 8)
        wr(CMD_CONTROL, 8'h0c);
        meas;
        `CHK(per, 0)
        base_highs(hi);
        `CHK(hi, 0)
        i_tcxo_bus_master.start;
        i_tcxo_bus_master.bx({adr, 1'b0}, 1'b1, q);
        i_tcxo_bus_master.bx(CMD_DIV_SEL, 1'b1, q);
        i_tcxo_bus_master.bx(8'h07, 1'b1, q);
        i_tcxo_bus_master.bx(8'h09, 1'b1, q);
        `CHK(q[0], 1'b1)
        i_tcxo_bus_master.stop;
        rd(CMD_DIV_SEL, 1);
        `CHK(b1, 8'h07)
        wr(CMD_TUNING, 8'hff);
        `CHK(comp_value, 12'h000)
        conv(10'h155);
        `CHK(comp_value, 12'h3ff)
        wr(CMD_TUNING, 8'h7f);
        conv(10'h2a9);
        `CHK(comp_value, 12'h47f)
        rd(CMD_TEMP_HI, 2);
        `CHK(b1, 8'haa)
        `CHK(b2, 8'h40)
        rd(CMD_TEMP_LO, 1);
        `CHK(b1, 8'h40)
        rd(CMD_TEMP_HI, 1);
        `CHK(b1, 8'haa)
        `CHK(sda_oe, 1'b0)
        i_tcxo_bus_master.start;
        i_tcxo_bus_master.bx({SLAVE_ADDR_BASE, 2'b00}, 1'b1, q);
        `CHK(q[0], 1'b1)
        i_tcxo_bus_master.stop;
        wr(CMD_CONTROL, 8'h04);
        meas;
        `CHK(per, 16)
        `CHK(hi, 1)
        base_highs(hi);
        `CHK(hi, 0)
        // the strap is caught once after reset, so move it under reset
        rst_b = 1'b0;
        adr_pin = 1'b0;
        repeat (12) @(posedge clk);
        #1;
        rst_b = 1'b1;
        repeat (20) @(posedge clk);
        #1;
        rd(CMD_TUNING, 1);
        `CHK(b1, TUNING_RESET)
        wr(CMD_DIV_SEL, 8'h05);
        rd(CMD_DIV_SEL, 1);
        `CHK(b1, 8'h05)
        i_tcxo_bus_master.start;
        i_tcxo_bus_master.bx({SLAVE_ADDR_BASE, 2'b10}, 1'b1, q);
        `CHK(q[0], 1'b1)
        i_tcxo_bus_master.stop;
        tally_and_finish;
    end
endmodule
bind tcxo_ctrl tcxo_ctrl_sva i_tcxo_ctrl_sva (.clk(clk), .rst_b(rst_b),
    .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .address_select_pin(address_select_pin), .sensor_data(sensor_data),
    .sensor_done(sensor_done), .factory_comp(factory_comp),
    .conv_start(conv_start), .comp_value(comp_value),
    .base_clock_out(base_clock_out), .divided_clock_out(divided_clock_out));
